// ===== rtl/moc_defines.svh
/*
 * Offsets, field positions, reset values and counts of the option block.
 * Assumes APB with word-aligned registers; index times four is the address.
 */
// Summary of operation
// R1 - The low-voltage monitor never raises an interrupt; it only resets or flags.
// R2 - With monitor power set, the monitor keeps running in wait mode.
// R3 - With monitor reset set, a trip in wait mode resets the chip out of wait.
// R4 - With power and stop-enable set, a trip in stop skips the filter and resets; the code resets only with monitor reset also set.
// R5 - With power set and stop-enable clear, the monitor is off in stop mode.
// R6 - Options are fixed; a write to the option register changes nothing.
// R7 - Read protect at 1 blocks program memory reads; at 0 they are allowed.
// R8 - Monitor reset at 1 lets the monitor reset the chip; at 0 it cannot.
// R9 - Monitor power at 1 powers the monitor; at 0 it is unpowered.
// R10 - Stop-enable at 1 keeps the monitor on in stop; at 0 it is off there.
// R11 - Short recovery leaves stop after 32 crystal cycles, else after 4096.
// R12 - Watchdog rate 1 gives 2^13-2^4 cycles, 0 gives 2^18-2^4 cycles.
// R13 - Stop-enable 1 lets stop execute; 0 makes it an illegal opcode.
// R14 - Watchdog disable 1 turns the watchdog off; 0 keeps it running.
// R15 - Outside stop, a reset needs nine consecutive cycles at or below trip.
// R16 - Options are constants, read back unchanged and valid from reset on; O_OPTIONS reads 0 until the third clock after I_ARST_N release.
`ifndef MOC_DEFINES_SVH
`define MOC_DEFINES_SVH

// -----------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------
`define MOC_IDX_OPT     10'h01f
`define MOC_IDX_STAT    10'h020
`define MOC_IDX_CTL     10'h021

// -----------------------------------------------------------------
// Option register fields
// -----------------------------------------------------------------
`define MOC_B_LVSTOP    7
`define MOC_B_RDPROT    6
`define MOC_B_LVRST     5
`define MOC_B_LVPWR     4
`define MOC_B_SHREC     3
`define MOC_B_WDRATE    2
`define MOC_B_STOPEN    1
`define MOC_B_WDDIS     0
`define MOC_OPT_RESET   8'h30

// -----------------------------------------------------------------
// Status and control fields
// -----------------------------------------------------------------
`define MOC_S_TRIP      0
`define MOC_S_WAIT      1
`define MOC_S_STOP      2
`define MOC_S_RECOV     3
`define MOC_S_ILL       4
`define MOC_C_WAIT      0
`define MOC_C_STOP      1
`define MOC_C_CLRILL    2

// -----------------------------------------------------------------
// Counts
// -----------------------------------------------------------------
`define MOC_RECOV_SHORT 13'h0020
`define MOC_RECOV_LONG  13'h1000
`define MOC_WDOG_SHORT  18'h01ff0
`define MOC_WDOG_LONG   18'h3fff0
`define MOC_LVM_FILT    4'h9

`endif

// ===== rtl/moc_pkg.sv
/*
 * Types of the option block: power mode and state records.
 * Assumes moc_defines.svh is compiled alongside.
 */
`default_nettype none
package moc_pkg;
	typedef enum logic [1:0] {
		MOC_RUN   = 2'b00,
		MOC_STOP  = 2'b01,
		MOC_RECOV = 2'b11,
		MOC_WAIT  = 2'b10
	} moc_mode_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic       trip;
		logic       rst_req;
	} moc_lvm_st_t;

	typedef struct packed {
		moc_mode_t   mode;
		logic [12:0] rec_cnt;
		logic        ill;
		logic        ill_pulse;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        chip_rst;
		logic        lvm_pwr;
		logic        rd_block;
		logic        wd_en;
		logic [17:0] wd_to;
		logic [7:0]  opts;
	} moc_top_st_t;
endpackage : moc_pkg
`default_nettype wire

// ===== rtl/moc_lvm.sv
/*
 * Low-voltage monitor: digital filter, stop bypass and reset request.
 * Assumes comparator levels synchronous to the clock.
 */
`include "moc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module moc_lvm (
	input  wire logic i_clk,     // System clock
	input  wire logic i_rst_n,   // Synced reset
	input  wire logic i_powered, // Monitor on
	input  wire logic i_in_stop, // Stop mode
	input  wire logic i_rst_en,  // Reset option
	input  wire logic i_below,   // Supply at or below trip
	input  wire logic i_above,   // Supply above rise level
	output logic      o_trip,    // Low-voltage flag
	output logic      o_rst_req  // Chip reset request
);
	moc_pkg::moc_lvm_st_t st;
	moc_pkg::moc_lvm_st_t next_st;

	always_comb begin
		next_st = st;
		if (!i_powered) begin
			next_st.cnt  = 4'h0;
			next_st.trip = 1'b0;
		end else if (i_below) begin
			if (i_in_stop)
				next_st.trip = 1'b1; // R4
			else if (st.cnt == `MOC_LVM_FILT - 4'h1)
				next_st.trip = 1'b1; // R15
			else
				next_st.cnt = st.cnt + 4'h1; // R15
		end else begin
			next_st.cnt = 4'h0;
			if (i_above)
				next_st.trip = 1'b0;
		end
		next_st.rst_req = next_st.trip && i_rst_en; // R8
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_trip    = st.trip;
	assign o_rst_req = st.rst_req;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// Run of low samples outside stop, saturating
	logic [3:0] low_run;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			low_run <= 4'h0;
		else if (!(i_below && i_powered && !i_in_stop))
			low_run <= 4'h0;
		else if (low_run != 4'hf)
			low_run <= low_run + 4'h1;
	end

	sequence s_low9;
		i_below && i_powered && !i_in_stop && low_run >= 4'h8;
	endsequence
	property p_filter;
		s_low9 |=> o_trip;
	endproperty
	a_filter: assert property (p_filter) // R15
		else $error("Trip missing after nine low cycles");

	property p_early;
		$rose(o_trip) && !$past(i_in_stop) |-> $past(st.cnt) == 4'h8;
	endproperty
	a_early: assert property (p_early) // R15
		else $error("Trip raised before nine low cycles");

	property p_bypass;
		i_in_stop && i_powered && i_below && i_rst_en |=> o_rst_req;
	endproperty
	a_bypass: assert property (p_bypass) // R4
		else $error("Stop trip did not bypass the filter");

	property p_no_rst;
		!$past(i_rst_en) |-> !o_rst_req;
	endproperty
	a_no_rst: assert property (p_no_rst) // R8
		else $error("Reset raised with reset option clear");
endmodule : moc_lvm
`default_nettype wire

// ===== rtl/moc_top.sv
/*
 * Fixed option block: read-only option register on APB, power modes,
 * stop recovery, watchdog and memory protect steering.
 * Assumes one 20 MHz clock serving as crystal and CPU clock.
 */
// Added by the designer: the APB interface to the registers.
`include "moc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module moc_top #(
	parameter logic [7:0]  OPTIONS    = `MOC_OPT_RESET,
	parameter logic [17:0] WDOG_LONG  = `MOC_WDOG_LONG,
	parameter logic [17:0] WDOG_SHORT = `MOC_WDOG_SHORT,
	parameter int          AW         = 12
) (
	input  wire logic          I_SYS_CLK,        // System clock
	input  wire logic          I_ARST_N,         // Async reset
	input  wire logic          I_PSEL,           // APB select
	input  wire logic          I_PENABLE,        // APB enable
	input  wire logic          I_PWRITE,         // APB write
	input  wire logic [AW-1:0] I_PADDR,          // APB address
	input  wire logic [31:0]   I_PWDATA,         // APB write data
	output logic      [31:0]   O_PRDATA,         // APB read data
	output logic               O_PREADY,         // APB ready
	output logic               O_PSLVERR,        // APB error
	input  wire logic          I_VDD_BELOW_TRIP, // Supply low
	input  wire logic          I_VDD_ABOVE_RISE, // Supply good
	input  wire logic          I_WAKE,           // Wake event
	input  wire logic          I_MEM_RD_REQ,     // External read
	output logic               O_MEM_RD_BLOCK,   // Read refused
	output logic               O_LVM_POWER_ON,   // Monitor power
	output logic               O_LVM_TRIP,       // Monitor flag
	output logic               O_CHIP_RESET,     // Monitor reset
	output logic               O_STOP_ILLEGAL,   // Illegal stop
	output logic               O_IN_WAIT,        // Wait mode
	output logic               O_IN_STOP,        // Stop or recover
	output logic               O_WDOG_ENABLE,    // Watchdog on
	output logic      [17:0]   O_WDOG_TIMEOUT,   // Timeout cycles
	output logic      [7:0]    O_OPTIONS         // Option bits
);
	// -----------------------------------------------------------------
	// Reset release
	// -----------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	moc_pkg::moc_top_st_t st;
	moc_pkg::moc_top_st_t next_st;

	logic          lvm_trip;
	logic          lvm_rst;
	logic          setup;
	logic          wr_acc;
	logic [AW-3:0] idx;
	logic [7:0]    status;
	logic [12:0]   rec_len;

	assign idx    = I_PADDR[AW-1:2];
	assign setup  = I_PSEL && !I_PENABLE;
	assign wr_acc = I_PSEL && I_PENABLE && st.pready && I_PWRITE;

	assign rec_len = OPTIONS[`MOC_B_SHREC] ?
		`MOC_RECOV_SHORT : `MOC_RECOV_LONG; // R11

	assign status = {3'h0,
		st.ill,
		st.mode == moc_pkg::MOC_RECOV,
		st.mode == moc_pkg::MOC_STOP,
		st.mode == moc_pkg::MOC_WAIT,
		lvm_trip};

	// -----------------------------------------------------------------
	// Monitor
	// -----------------------------------------------------------------
	// No interrupt path leaves the monitor: only reset and flag. R1
	moc_lvm u_lvm (
		.i_clk     (I_SYS_CLK),
		.i_rst_n   (rst_n),
		.i_powered (st.lvm_pwr),
		.i_in_stop (st.mode == moc_pkg::MOC_STOP),
		.i_rst_en  (OPTIONS[`MOC_B_LVRST]),
		.i_below   (I_VDD_BELOW_TRIP),
		.i_above   (I_VDD_ABOVE_RISE),
		.o_trip    (lvm_trip),
		.o_rst_req (lvm_rst)
	);

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		next_st           = st;
		next_st.ill_pulse = 1'b0;
		next_st.pready    = 1'b0;
		next_st.pslverr   = 1'b0;
		next_st.prdata    = 32'h0;
		next_st.opts      = OPTIONS; // R16

		// Register reads and decode
		if (setup) begin
			next_st.pready = 1'b1;
			unique case (idx)
				`MOC_IDX_OPT:  next_st.prdata = {24'h0, OPTIONS}; // R16
				`MOC_IDX_STAT: next_st.prdata = {24'h0, status};
				`MOC_IDX_CTL:  next_st.prdata = 32'h0;
				default:       next_st.pslverr = 1'b1;
			endcase
		end

		// Option writes fall through with no effect R6
		if (wr_acc && idx == `MOC_IDX_CTL
				&& I_PWDATA[`MOC_C_CLRILL])
			next_st.ill = 1'b0;

		// Power mode sequencing
		unique case (st.mode)
			moc_pkg::MOC_RUN: begin
				if (wr_acc && idx == `MOC_IDX_CTL) begin
					if (I_PWDATA[`MOC_C_STOP]) begin
						if (OPTIONS[`MOC_B_STOPEN]) begin
							next_st.mode = moc_pkg::MOC_STOP; // R13
						end else begin
							next_st.ill_pulse = 1'b1; // R13
							next_st.ill       = 1'b1; // R13
						end
					end else if (I_PWDATA[`MOC_C_WAIT]) begin
						next_st.mode = moc_pkg::MOC_WAIT;
					end
				end
			end
			moc_pkg::MOC_WAIT: begin
				if (I_WAKE)
					next_st.mode = moc_pkg::MOC_RUN;
			end
			moc_pkg::MOC_STOP: begin
				if (I_WAKE) begin
					next_st.mode    = moc_pkg::MOC_RECOV;
					next_st.rec_cnt = rec_len - 13'h1; // R11
				end
			end
			moc_pkg::MOC_RECOV: begin
				if (st.rec_cnt == 13'h0)
					next_st.mode = moc_pkg::MOC_RUN; // R11
				else
					next_st.rec_cnt = st.rec_cnt - 13'h1;
			end
		endcase

		// Monitor reset ends wait or stop at once R3
		if (lvm_rst)
			next_st.mode = moc_pkg::MOC_RUN; // R4
		next_st.chip_rst = lvm_rst; // R8

		// Monitor power by mode R9
		next_st.lvm_pwr = OPTIONS[`MOC_B_LVPWR]
			&& !(next_st.mode == moc_pkg::MOC_STOP
			&& !OPTIONS[`MOC_B_LVSTOP]); // R2 R5 R10

		next_st.rd_block = I_MEM_RD_REQ && OPTIONS[`MOC_B_RDPROT]; // R7
		next_st.wd_en    = !OPTIONS[`MOC_B_WDDIS]; // R14
		next_st.wd_to    = OPTIONS[`MOC_B_WDRATE] ?
			WDOG_SHORT : WDOG_LONG; // R12
	end

	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign O_PRDATA       = st.prdata;
	assign O_PREADY       = st.pready;
	assign O_PSLVERR      = st.pslverr;
	assign O_MEM_RD_BLOCK = st.rd_block;
	assign O_LVM_POWER_ON = st.lvm_pwr;
	assign O_LVM_TRIP     = lvm_trip;
	assign O_CHIP_RESET   = st.chip_rst;
	assign O_STOP_ILLEGAL = st.ill_pulse;
	assign O_IN_WAIT      = st.mode == moc_pkg::MOC_WAIT;
	assign O_IN_STOP      = st.mode[0];
	assign O_WDOG_ENABLE  = st.wd_en;
	assign O_WDOG_TIMEOUT = st.wd_to;
	assign O_OPTIONS      = st.opts;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!rst_n);

	logic        in_wait_q;
	logic [12:0] rec_seen;

	always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rec_seen  <= 13'h0;
			in_wait_q <= 1'b0;
		end else begin
			in_wait_q <= O_IN_WAIT;
			if (st.mode == moc_pkg::MOC_RECOV)
				rec_seen <= rec_seen + 13'h1;
			else
				rec_seen <= 13'h0;
		end
	end

	property p_opt_read;
		I_PSEL && I_PENABLE && O_PREADY && !I_PWRITE
			&& idx == `MOC_IDX_OPT
			|-> O_PRDATA == {24'h0, OPTIONS} && !O_PSLVERR;
	endproperty
	a_opt_read: assert property (p_opt_read) // R16
		else $error("Option read returned a wrong value");

	property p_opt_write;
		wr_acc && idx == `MOC_IDX_OPT
			|=> O_OPTIONS == OPTIONS ##1 O_OPTIONS == OPTIONS;
	endproperty
	a_opt_write: assert property (p_opt_write) // R6
		else $error("Option write changed the options");

	property p_rd_block;
		I_MEM_RD_REQ |=> O_MEM_RD_BLOCK == OPTIONS[`MOC_B_RDPROT];
	endproperty
	a_rd_block: assert property (p_rd_block) // R7
		else $error("Memory read protect wrong");

	sequence s_stop_req;
		wr_acc && idx == `MOC_IDX_CTL && I_PWDATA[`MOC_C_STOP]
			&& st.mode == moc_pkg::MOC_RUN && !lvm_rst;
	endsequence
	property p_stop_req;
		s_stop_req |=> (O_IN_STOP == OPTIONS[`MOC_B_STOPEN])
			&& (O_STOP_ILLEGAL != OPTIONS[`MOC_B_STOPEN]);
	endproperty
	a_stop_req: assert property (p_stop_req) // R13
		else $error("Stop request handled wrongly");

	property p_recov;
		$fell(st.mode == moc_pkg::MOC_RECOV) && !$past(lvm_rst)
			|-> rec_seen == rec_len;
	endproperty
	a_recov: assert property (p_recov) // R11
		else $error("Stop recovery length wrong");

	property p_wdog;
		$past(rst_n) |-> O_WDOG_ENABLE == !OPTIONS[`MOC_B_WDDIS]
			&& O_WDOG_TIMEOUT == (OPTIONS[`MOC_B_WDRATE] ?
			WDOG_SHORT : WDOG_LONG);
	endproperty
	a_wdog: assert property (p_wdog) // R12
		else $error("Watchdog selection wrong");

	property p_pwr_wait;
		O_IN_WAIT |-> O_LVM_POWER_ON == OPTIONS[`MOC_B_LVPWR];
	endproperty
	a_pwr_wait: assert property (p_pwr_wait) // R2
		else $error("Monitor power wrong in wait");

	property p_pwr_stop;
		st.mode == moc_pkg::MOC_STOP |-> O_LVM_POWER_ON
			== (OPTIONS[`MOC_B_LVPWR] && OPTIONS[`MOC_B_LVSTOP]);
	endproperty
	a_pwr_stop: assert property (p_pwr_stop) // R5
		else $error("Monitor power wrong in stop");

	property p_wait_rst;
		in_wait_q && lvm_rst |-> ##1 O_CHIP_RESET && !O_IN_WAIT;
	endproperty
	a_wait_rst: assert property (p_wait_rst) // R3
		else $error("Monitor reset did not end wait");

	// -----------------------------------------------------------------
	// Bus, power and mode checks
	// -----------------------------------------------------------------
	property p_ready;
		setup |=> O_PREADY ##1 !O_PREADY;
	endproperty
	a_ready: assert property (p_ready) // R16
		else $error("Ready pulse wrong");

	property p_opt_noerr;
		wr_acc && idx == `MOC_IDX_OPT |-> !O_PSLVERR;
	endproperty
	a_opt_noerr: assert property (p_opt_noerr) // R6
		else $error("Option write flagged an error");

	property p_pwr_run;
		$past(rst_n) && st.mode != moc_pkg::MOC_STOP
			|-> O_LVM_POWER_ON == OPTIONS[`MOC_B_LVPWR];
	endproperty
	a_pwr_run: assert property (p_pwr_run) // R9
		else $error("Monitor power wrong outside stop");

	property p_unpowered;
		!OPTIONS[`MOC_B_LVPWR] |-> !O_LVM_TRIP && !O_CHIP_RESET;
	endproperty
	a_unpowered: assert property (p_unpowered) // R9
		else $error("Unpowered monitor tripped");

	property p_rst_follow;
		O_CHIP_RESET == $past(lvm_rst);
	endproperty
	a_rst_follow: assert property (p_rst_follow) // R8
		else $error("Chip reset does not follow monitor request");

	property p_ill_sticky;
		O_STOP_ILLEGAL |-> st.ill;
	endproperty
	a_ill_sticky: assert property (p_ill_sticky) // R13
		else $error("Illegal stop pulse without sticky flag");

	sequence s_stop_trip;
		st.mode == moc_pkg::MOC_STOP && O_LVM_POWER_ON
			&& I_VDD_BELOW_TRIP && OPTIONS[`MOC_B_LVRST];
	endsequence
	sequence s_reset_out;
		O_CHIP_RESET && !O_IN_STOP;
	endsequence
	property p_stop_trip;
		s_stop_trip |=> ##1 s_reset_out;
	endproperty
	a_stop_trip: assert property (p_stop_trip) // R4
		else $error("Trip in stop did not reset the chip");

	property p_wake_stop;
		st.mode == moc_pkg::MOC_STOP && I_WAKE && !lvm_rst |=> O_IN_STOP;
	endproperty
	a_wake_stop: assert property (p_wake_stop) // R11
		else $error("Stop left without recovery delay");

	property p_rd_idle;
		!I_MEM_RD_REQ |=> !O_MEM_RD_BLOCK;
	endproperty
	a_rd_idle: assert property (p_rd_idle) // R7
		else $error("Read refused with no request");
endmodule : moc_top
`default_nettype wire

// ===== test/mask_option_config_bench.sv
/*
 * Self-checking bench of the fixed option block: three instances with
 * different option sets share one APB master and one supply drive.
 * Assumes moc_defines.svh and the design files are compiled first.
 */
`include "moc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mask_option_config_bench;
	localparam int          N     = 3;
	localparam logic [7:0]  OPTS [N] = '{8'hfe, 8'h13, 8'h21};
	localparam logic [17:0] TO_S  = 18'((1 << 13) - (1 << 4));
	localparam logic [17:0] TO_L  = 18'((1 << 18) - (1 << 4));
	logic        clk     = 1'b0;
	logic        arst_n  = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic        below   = 1'b0;
	logic        above   = 1'b0;
	logic        wake    = 1'b0;
	logic        rd_req  = 1'b0;
	logic [31:0] prdata [N];
	logic        pready [N];
	logic        pslverr [N];
	logic        rd_blk [N];
	logic        pwr_on [N];
	logic        trip [N];
	logic        c_rst [N];
	logic        s_ill [N];
	logic        in_wait [N];
	logic        in_stop [N];
	logic        wd_en [N];
	logic [17:0] wd_to [N];
	logic [7:0]  opts [N];
	logic [31:0] rd_v [N];
	logic        rd_err;
	int          mismatches = 0;
	int          cmp_count  = 0;

	always #25 clk = ~clk;

	for (genvar i = 0; i < N; i++) begin : g_dut
		moc_top #(.OPTIONS(OPTS[i])) dut (
			.I_SYS_CLK(clk), .I_ARST_N(arst_n),
			.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
			.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata[i]),
			.O_PREADY(pready[i]), .O_PSLVERR(pslverr[i]),
			.I_VDD_BELOW_TRIP(below), .I_VDD_ABOVE_RISE(above),
			.I_WAKE(wake), .I_MEM_RD_REQ(rd_req),
			.O_MEM_RD_BLOCK(rd_blk[i]), .O_LVM_POWER_ON(pwr_on[i]),
			.O_LVM_TRIP(trip[i]), .O_CHIP_RESET(c_rst[i]),
			.O_STOP_ILLEGAL(s_ill[i]), .O_IN_WAIT(in_wait[i]),
			.O_IN_STOP(in_stop[i]), .O_WDOG_ENABLE(wd_en[i]),
			.O_WDOG_TIMEOUT(wd_to[i]), .O_OPTIONS(opts[i])
		);
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic ob(input int k, input int b);
		return OPTS[k][b];
	endfunction : ob

	task automatic chk_bit(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic apb(input logic wr, input logic [9:0] idx,
		input logic [31:0] wd);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready[0] !== 1'b1);
		for (int k = 0; k < N; k++)
			rd_v[k] = prdata[k];
		rd_err = pslverr[0];
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic low_supply(input int n);
		@(posedge clk);
		below <= 1'b1;
		repeat (n) @(posedge clk);
		below <= 1'b0;
		tick(3);
	endtask : low_supply

	task automatic clear_trip();
		@(posedge clk);
		above <= 1'b1;
		repeat (2) @(posedge clk);
		above <= 1'b0;
		tick(2);
	endtask : clear_trip

	task automatic pulse_wake();
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
	endtask : pulse_wake

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_static();
		for (int k = 0; k < N; k++) begin
			chk_word("options", 32'(OPTS[k]), 32'(opts[k]));
			chk_bit("wdog_en", ~ob(k, `MOC_B_WDDIS), wd_en[k]);
			chk_word("wdog_to", ob(k, `MOC_B_WDRATE) ? 32'(TO_S) : 32'(TO_L),
				32'(wd_to[k]));
			chk_bit("lvm_pwr", ob(k, `MOC_B_LVPWR), pwr_on[k]);
			chk_bit("rd_idle", 1'b0, rd_blk[k]);
		end
	endtask : t_static

	task automatic t_regs();
		apb(1'b0, `MOC_IDX_OPT, 32'h0);
		for (int k = 0; k < N; k++)
			chk_word("opt_read", 32'(OPTS[k]), rd_v[k]);
		apb(1'b1, `MOC_IDX_OPT, 32'hffffffff);
		apb(1'b0, `MOC_IDX_OPT, 32'h0);
		for (int k = 0; k < N; k++) begin
			chk_word("opt_reread", 32'(OPTS[k]), rd_v[k]);
			chk_word("opt_port", 32'(OPTS[k]), 32'(opts[k]));
		end
		apb(1'b0, 10'h3ff, 32'h0);
		chk_bit("unmapped_err", 1'b1, rd_err);
		chk_word("unmapped_data", 32'h0, rd_v[0]);
		@(posedge clk);
		rd_req <= 1'b1;
		tick(2);
		for (int k = 0; k < N; k++)
			chk_bit("rd_block", ob(k, `MOC_B_RDPROT), rd_blk[k]);
		@(posedge clk) rd_req <= 1'b0;
	endtask : t_regs

	task automatic t_filter();
		low_supply(8);
		for (int k = 0; k < N; k++)
			chk_bit("trip_short", 1'b0, trip[k]);
		low_supply(9);
		for (int k = 0; k < N; k++) begin
			chk_bit("trip", ob(k, `MOC_B_LVPWR), trip[k]);
			chk_bit("chip_rst", ob(k, `MOC_B_LVPWR) & ob(k, `MOC_B_LVRST),
				c_rst[k]);
		end
		clear_trip();
		for (int k = 0; k < N; k++)
			chk_bit("trip_clear", 1'b0, trip[k]);
	endtask : t_filter

	task automatic t_wait();
		apb(1'b1, `MOC_IDX_CTL, 32'h1 << `MOC_C_WAIT);
		tick(2);
		for (int k = 0; k < N; k++) begin
			chk_bit("in_wait", 1'b1, in_wait[k]);
			chk_bit("pwr_wait", ob(k, `MOC_B_LVPWR), pwr_on[k]);
		end
		low_supply(9);
		for (int k = 0; k < N; k++)
			chk_bit("wait_exit", ~(ob(k, `MOC_B_LVPWR) & ob(k, `MOC_B_LVRST)),
				in_wait[k]);
		clear_trip();
		pulse_wake();
		tick(2);
		for (int k = 0; k < N; k++)
			chk_bit("wait_wake", 1'b0, in_wait[k]);
	endtask : t_wait

	task automatic t_stop();
		int last [N];
		int rec;
		apb(1'b1, `MOC_IDX_CTL, 32'h1 << `MOC_C_STOP);
		#1;
		for (int k = 0; k < N; k++)
			chk_bit("stop_ill", ~ob(k, `MOC_B_STOPEN), s_ill[k]);
		tick(2);
		for (int k = 0; k < N; k++) begin
			last[k] = 0;
			chk_bit("ill_pulse", 1'b0, s_ill[k]);
			chk_bit("in_stop", ob(k, `MOC_B_STOPEN), in_stop[k]);
			chk_bit("pwr_stop", ob(k, `MOC_B_LVPWR) &
				(ob(k, `MOC_B_LVSTOP) | ~ob(k, `MOC_B_STOPEN)),
				pwr_on[k]);
		end
		apb(1'b0, `MOC_IDX_STAT, 32'h0);
		for (int k = 0; k < N; k++)
			chk_bit("ill_sticky", ~ob(k, `MOC_B_STOPEN),
				rd_v[k][`MOC_S_ILL]);
		apb(1'b1, `MOC_IDX_CTL, 32'h1 << `MOC_C_CLRILL);
		apb(1'b0, `MOC_IDX_STAT, 32'h0);
		chk_bit("ill_cleared", 1'b0, rd_v[2][`MOC_S_ILL]);
		pulse_wake();
		for (int n = 1; n <= 4200; n++) begin
			@(posedge clk);
			#1;
			for (int k = 0; k < N; k++)
				if (in_stop[k] === 1'b1)
					last[k] = n;
		end
		for (int k = 0; k < N; k++) begin
			rec = ob(k, `MOC_B_SHREC) ? 32 : 4096;
			if (ob(k, `MOC_B_STOPEN))
				chk_word("recov_len", 32'(rec - 1), 32'(last[k]));
			else
				chk_word("no_stop", 32'h0, 32'(last[k]));
		end
	endtask : t_stop

	task automatic t_stop_trip();
		logic on;
		apb(1'b1, `MOC_IDX_CTL, 32'h1 << `MOC_C_STOP);
		tick(2);
		low_supply(1);
		for (int k = 0; k < N; k++) begin
			on = ob(k, `MOC_B_LVPWR) & ob(k, `MOC_B_LVSTOP) &
				ob(k, `MOC_B_STOPEN);
			chk_bit("stop_trip", on, trip[k]);
			chk_bit("stop_rst", on & ob(k, `MOC_B_LVRST), c_rst[k]);
			chk_bit("stop_exit", ob(k, `MOC_B_STOPEN) &
				~(on & ob(k, `MOC_B_LVRST)), in_stop[k]);
		end
		clear_trip();
		pulse_wake();
		for (int n = 0; n < 4200 && in_stop[1] === 1'b1; n++)
			tick(1);
		chk_bit("stop_done", 1'b0, in_stop[1]);
	endtask : t_stop_trip

	// ---------------------------------------------------------------
	// Run control
	// ---------------------------------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#1000000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		tick(5);
		t_static();
		t_regs();
		t_filter();
		t_wait();
		t_stop();
		t_stop_trip();
		t_static();
		report_and_stop();
	end
endmodule : mask_option_config_bench
`default_nettype wire
